// ---- hdl/ubfc_map.vh ----
// Purpose: Register offsets, field positions, reset values and counts for the serial port configuration block.
// Assumes: Byte-wide registers on a plain address port.
// Notes: Definitions only.
`ifndef UBFC_MAP_VH
`define UBFC_MAP_VH
`define UBFC_ADDR_W 3
`define UBFC_OFF_BDH 3'h0
`define UBFC_OFF_BDL 3'h1
`define UBFC_OFF_FOC 3'h2
`define UBFC_OFF_CTL2 3'h3
`define UBFC_OFF_STAT 3'h4
`define UBFC_BDH_RST 8'h00
`define UBFC_BDL_RST 8'h04
`define UBFC_FOC_RST 8'h00
`define UBFC_CTL2_RST 8'h00
`define UBFC_BDH_LBKIE 7
`define UBFC_BDH_RXEIE 6
`define UBFC_FOC_LOOP 7
`define UBFC_FOC_WFRZ 6
`define UBFC_FOC_RX_SOURCE_SEL 5
`define UBFC_FOC_NINE 4
`define UBFC_FOC_WAKE 3
`define UBFC_FOC_ILT 2
`define UBFC_FOC_PEN 1
`define UBFC_FOC_PODD 0
`define UBFC_C2_TXON 3
`define UBFC_C2_RXON 2
`define UBFC_C2_DIR 0
`define UBFC_TICKS_PER_BIT 5'h10
`define UBFC_IDLE_SHORT 4'ha
`define UBFC_IDLE_LONG 4'hb
`endif

// ---- hdl/ubfc_uart_baud_and_frame_config.v ----
// Purpose: Baud generator and frame/option configuration for a serial port.
// Assumes: One clock core_clk at 100 MHz, asynchronous active-low reset rstn.
// Notes: Shifters and status flags live elsewhere; this block exports settings and routing.
`timescale 1ns/100ps
`include "ubfc_map.vh"

module ubfc_uart_baud_and_frame_config (
  input wire core_clk,
  input wire rstn,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire cpuWait,
  input wire lineBreakFlag,
  input wire rxEdgeFlag,
  input wire txSerialOut,
  input wire receivePin,
  input wire transmitPinIn,
  output wire transmitPinOut,
  output wire transmitPinOe,
  output wire rxSerialIn,
  output wire sampleTick,
  output wire bitTick,
  output wire baudRunning,
  output wire portClkEn,
  output wire irqRequest,
  output wire charLenNine,
  output wire wakeAddrMark,
  output wire idleCountAfterStop,
  output wire [3:0] idleBitCount,
  output wire parityOn,
  output wire parityOddSelect,
  output wire txOn,
  output wire rxOn,
  output wire [12:0] baudModulo
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [7:0] bdhWork_r;
  reg [7:0] bdhBuf_r;
  reg [7:0] bdl_r;
  reg [7:0] foc_r;
  reg [7:0] ctl2_r;
  reg armed_r;
  reg [12:0] baudCnt_r;
  reg [12:0] baudCnt_nxt;
  reg [3:0] tickCnt_r;
  reg [2:0] rxPinSync_r;
  reg rxPinStable_r;
  reg [2:0] txPinSync_r;
  reg txPinStable_r;
  reg [7:0] rdMux;

  // Decodes a register offset against the bus address.
  function hit;
    input [2:0] addr;
    input [2:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // High byte lands in a buffer; the working copy's modulo bits 4:0 move on a low-byte write.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bdhBuf_r <= `UBFC_BDH_RST;
      bdhWork_r <= `UBFC_BDH_RST;
      bdl_r <= `UBFC_BDL_RST;
      foc_r <= `UBFC_FOC_RST;
      ctl2_r <= `UBFC_CTL2_RST;
      armed_r <= 1'b0;
    end else begin
      if (regWr && hit(regAddr, `UBFC_OFF_BDH)) begin
        bdhBuf_r <= regWdata;
        bdhWork_r[7:5] <= regWdata[7:5]; // Interrupt enables act at once.
      end
      if (regWr && hit(regAddr, `UBFC_OFF_BDL)) begin
        bdl_r <= regWdata;
        bdhWork_r[4:0] <= bdhBuf_r[4:0];
      end
      if (regWr && hit(regAddr, `UBFC_OFF_FOC)) begin
        foc_r <= regWdata;
      end
      if (regWr && hit(regAddr, `UBFC_OFF_CTL2)) begin
        ctl2_r <= regWdata;
        // Generator stays off until an enable is first written to one.
        if (regWdata[`UBFC_C2_TXON] || regWdata[`UBFC_C2_RXON]) begin
          armed_r <= 1'b1;
        end
      end
    end
  end

  // Read mux; unmapped offsets read zero, high byte shows the buffered value with bit 5 read as zero.
  always @* begin
    rdMux = 8'h00;
    if (hit(regAddr, `UBFC_OFF_BDH)) begin
      rdMux = {bdhBuf_r[7:6], 1'b0, bdhBuf_r[4:0]};
    end else if (hit(regAddr, `UBFC_OFF_BDL)) begin
      rdMux = bdl_r;
    end else if (hit(regAddr, `UBFC_OFF_FOC)) begin
      rdMux = foc_r;
    end else if (hit(regAddr, `UBFC_OFF_CTL2)) begin
      rdMux = ctl2_r;
    end else if (hit(regAddr, `UBFC_OFF_STAT)) begin
      rdMux = {3'h0, irqRequest, baudRunning, portClkEn, rxPinStable_r, txPinStable_r};
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  assign baudModulo = {bdhWork_r[4:0], bdl_r};
  // Frozen clocks in CPU wait when freeze is chosen.
  assign portClkEn = !(foc_r[`UBFC_FOC_WFRZ] && cpuWait);
  assign baudRunning = armed_r && (baudModulo != 13'h0000);

  // Counter counts modulo baudModulo, one sample tick per wrap.
  always @* begin
    baudCnt_nxt = baudCnt_r;
    if (!baudRunning) begin
      baudCnt_nxt = 13'h0000;
    end else if (portClkEn) begin
      if (baudCnt_r >= baudModulo - 13'h0001) begin
        baudCnt_nxt = 13'h0000;
      end else begin
        baudCnt_nxt = baudCnt_r + 13'h0001;
      end
    end
  end

  assign sampleTick = baudRunning && portClkEn && (baudCnt_r >= baudModulo - 13'h0001);

  // Sixteen sample ticks make one bit period.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baudCnt_r <= 13'h0000;
      tickCnt_r <= 4'h0;
    end else begin
      baudCnt_r <= baudCnt_nxt;
      if (!baudRunning) begin
        tickCnt_r <= 4'h0;
      end else if (sampleTick) begin
        tickCnt_r <= tickCnt_r + 4'h1;
      end
    end
  end

  assign bitTick = sampleTick && (tickCnt_r == 4'hf);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts when stages two and three agree.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxPinSync_r <= 3'h7;
      txPinSync_r <= 3'h7;
      rxPinStable_r <= 1'b1;
      txPinStable_r <= 1'b1;
    end else begin
      rxPinSync_r <= {rxPinSync_r[1:0], receivePin};
      txPinSync_r <= {txPinSync_r[1:0], transmitPinIn};
      if (rxPinSync_r[1] == rxPinSync_r[2]) begin
        rxPinStable_r <= rxPinSync_r[2];
      end
      if (txPinSync_r[1] == txPinSync_r[2]) begin
        txPinStable_r <= txPinSync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Line routing
  // ----------------------------------------------------------------
  // Source select only matters with loopback on.
  assign rxSerialIn = !foc_r[`UBFC_FOC_LOOP] ? rxPinStable_r :
                      !foc_r[`UBFC_FOC_RX_SOURCE_SEL] ? txSerialOut :
                      (ctl2_r[`UBFC_C2_DIR] ? txSerialOut : txPinStable_r);
  assign transmitPinOut = txSerialOut;
  // Single-wire: direction bit chooses drive or listen; otherwise transmitter owns pin.
  assign transmitPinOe = ctl2_r[`UBFC_C2_TXON] &&
                         (!(foc_r[`UBFC_FOC_LOOP] && foc_r[`UBFC_FOC_RX_SOURCE_SEL]) || ctl2_r[`UBFC_C2_DIR]);

  // ----------------------------------------------------------------
  // Interrupt request and frame settings
  // ----------------------------------------------------------------
  assign irqRequest = (bdhWork_r[`UBFC_BDH_LBKIE] && lineBreakFlag) ||
                      (bdhWork_r[`UBFC_BDH_RXEIE] && rxEdgeFlag);
  assign charLenNine = foc_r[`UBFC_FOC_NINE];
  assign wakeAddrMark = foc_r[`UBFC_FOC_WAKE];
  assign idleCountAfterStop = foc_r[`UBFC_FOC_ILT];
  assign idleBitCount = foc_r[`UBFC_FOC_NINE] ? `UBFC_IDLE_LONG : `UBFC_IDLE_SHORT;
  assign parityOn = foc_r[`UBFC_FOC_PEN];
  assign parityOddSelect = foc_r[`UBFC_FOC_PODD];
  assign txOn = ctl2_r[`UBFC_C2_TXON];
  assign rxOn = ctl2_r[`UBFC_C2_RXON];

endmodule

// ---- sim/ubfc_properties.sv ----
// Purpose: Port checks for the serial configuration block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to the configuration block by the bind statement below.
`timescale 1ns/100ps
module ubfc_properties (
  input wire core_clk,
  input wire rstn,
  input wire regRd,
  input wire [7:0] regRdata,
  input wire lineBreakFlag,
  input wire rxEdgeFlag,
  input wire txSerialOut,
  input wire transmitPinOut,
  input wire transmitPinOe,
  input wire sampleTick,
  input wire bitTick,
  input wire baudRunning,
  input wire portClkEn,
  input wire irqRequest,
  input wire charLenNine,
  input wire [3:0] idleBitCount,
  input wire txOn,
  input wire [12:0] baudModulo
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_pin_follow: assert property (transmitPinOut == txSerialOut)
    else $error("pin differs from shifter");
  a_zero_off: assert property (baudModulo == 13'h0000 |-> !sampleTick && !baudRunning)
    else $error("generator active at zero");
  a_freeze_stop: assert property (!portClkEn |-> !sampleTick)
    else $error("tick while frozen");
  a_tick_gap: assert property (sampleTick && baudModulo > 13'h0002 ##1 $stable(baudModulo) |-> !sampleTick)
    else $error("ticks too close");
  a_bit_sub: assert property (bitTick |-> sampleTick)
    else $error("bit tick without sample tick");
  a_irq_cause: assert property (irqRequest |-> lineBreakFlag || rxEdgeFlag)
    else $error("request without flag");
  a_idle_len: assert property (idleBitCount == (charLenNine ? 4'hb : 4'ha))
    else $error("idle length wrong");
  a_oe_tx: assert property (transmitPinOe |-> txOn)
    else $error("pin driven with transmitter off");
  a_read_gap: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind ubfc_uart_baud_and_frame_config ubfc_properties chk (.*);

// ---- sim/ubfc_far_end.sv ----
// Purpose: Far serial device holding the shared line.
// Assumes: The line has a pull-up.
// Notes: Level drive only.
`timescale 1ns/100ps
module ubfc_far_end (
  input wire drive,
  input wire lvl,
  output wire line
);
  // A released line rests at the idle mark level.
  assign line = drive ? lvl : 1'b1;
endmodule

// ---- sim/ubfc_uart_baud_and_frame_config_test.sv ----
// Purpose: Self-checking bench for the serial configuration block.
// Assumes: 100 MHz clock, reset low for five cycles.
// Notes: Register reads are checked from a queue.
`timescale 1ns/100ps
module ubfc_uart_baud_and_frame_config_test;
  logic core_clk = 0, rstn = 0, regWr = 0, regRd = 0, cpuWait = 0, lineBreakFlag = 0, rxEdgeFlag = 0;
  logic txSerialOut = 1, receivePin = 1, rdSeen = 0, e1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, en;
  logic [12:0] m, prev = 13'h0004;
  wire [7:0] regRdata;
  wire [3:0] idleBitCount;
  wire [12:0] baudModulo;
  wire transmitPinOut, transmitPinOe, rxSerialIn, sampleTick, bitTick, baudRunning, portClkEn, irqRequest;
  wire charLenNine, wakeAddrMark, idleCountAfterStop, parityOn, parityOddSelect, txOn, rxOn, farLine;
  wire transmitPinIn = transmitPinOe ? transmitPinOut : farLine;
  logic [7:0] expQ[$];
  int badCount = 0, samplesChecked = 0, seed = 26, t, b;
  localparam logic [10:0] IRQ_TAB [4] = '{11'h405, 11'h004, 11'h203, 11'h402};
  localparam logic [17:0] ROUTE_TAB [5] = '{18'h00020, 18'h08020, 18'h20021, 18'h28025, 18'h28022};
  ubfc_uart_baud_and_frame_config uut (.*);
  ubfc_far_end far (.drive(~transmitPinOe), .lvl(1'b0), .line(farLine));
  always #5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    // One idle edge keeps a following write from reassigning the strobe in this step.
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    expQ.push_back(e);
  endtask
  task automatic count(input int n);
    t = 0;
    b = 0;
    repeat (n) begin
      @(posedge core_clk);
      t += sampleTick;
      b += bitTick;
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Compares each read answer with the oldest expectation.
  always @(posedge core_clk) begin
    if (rdSeen) chk("regRdata", {5'h00, expQ.pop_front()}, {5'h00, regRdata});
    rdSeen <= regRd;
  end
  // Cuts a hang short.
  initial begin
    #100000;
    badCount++;
    close_out;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(3'h1, 8'h04);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    chk("baudRunning", 0, baudRunning);
    for (int i = 0; i < 4; i++) begin
      m = 13'($random(seed));
      wr(3'h0, {3'h0, m[12:8]});
      @(posedge core_clk);
      chk("heldModulo", prev, baudModulo);
      rd(3'h0, {3'h0, m[12:8]});
      wr(3'h1, m[7:0]);
      @(posedge core_clk);
      chk("baudModulo", m, baudModulo);
      prev = m;
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h08);
    count(40);
    chk("zeroTicks", 0, t + baudRunning);
    wr(3'h1, 8'h03);
    count(96);
    chk("sampleTicks", 32, t);
    chk("bitTicks", 2, b);
    wr(3'h2, 8'h40);
    cpuWait <= 1'b1;
    count(20);
    chk("frozenTicks", 0, t + portClkEn);
    wr(3'h2, 8'h00);
    @(posedge core_clk);
    chk("portClkEn", 1, portClkEn);
    cpuWait <= 1'b0;
    $display("baud tests done");
    for (int i = 0; i < 4; i++) begin
      en = IRQ_TAB[i][10:3];
      e1 = IRQ_TAB[i][0];
      lineBreakFlag <= IRQ_TAB[i][2];
      rxEdgeFlag <= IRQ_TAB[i][1];
      wr(3'h0, en);
      @(posedge core_clk);
      chk("irqRequest", e1, irqRequest);
    end
    $display("interrupt tests done");
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, ROUTE_TAB[i][17:10]);
      wr(3'h3, ROUTE_TAB[i][9:2]);
      for (int p = 0; p < 2; p++) begin
        receivePin <= p[0];
        txSerialOut <= ~p[0];
        repeat (5) @(posedge core_clk);
        e1 = ROUTE_TAB[i][1] ? 1'b0 : ROUTE_TAB[i][0] ? ~p[0] : p[0];
        chk("rxSerialIn", e1, rxSerialIn);
        if (ROUTE_TAB[i][17:10] == 8'ha0) chk("transmitPinOe", ROUTE_TAB[i][2], transmitPinOe);
      end
    end
    $display("routing tests done");
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, 8'h01 << i);
      rd(3'h2, 8'h01 << i);
      chk("frameBits", 5'h01 << i, {charLenNine, wakeAddrMark, idleCountAfterStop, parityOn, parityOddSelect});
    end
    $display("frame tests done");
    repeat (3) @(posedge core_clk);
    close_out;
  end
endmodule
